// ### logic/apm_pkg.sv
// Package: register map, field positions and timing constants for the power and output configuration block
package apm_pkg;
  localparam logic [7:0] APM_POWER_STATE_CTRL_OFFS = 8'h11;
  localparam logic [7:0] APM_LOW_POWER_CFG_OFFS = 8'h12;
  localparam logic [7:0] APM_DATA_OUTPUT_FORMAT_CFG_OFFS = 8'h13;
  localparam logic [7:0] APM_POWER_STATE_CTRL_RESET = 8'h00;
  localparam logic [7:0] APM_LOW_POWER_CFG_RESET = 8'h00;
  localparam logic [7:0] APM_DATA_OUTPUT_FORMAT_CFG_RESET = 8'h00;
  // Field positions in power_state_ctrl
  localparam int APM_SUSPEND_BIT = 7;
  localparam int APM_LOWPOWER_EN_BIT = 6;
  localparam int APM_DEEP_SLEEP_BIT = 5;
  localparam int APM_SLEEP_DUR_LSB = 1;
  localparam logic [7:0] APM_POWER_STATE_CTRL_MASK = 8'hfe;
  // Field positions in low_power_cfg
  localparam int APM_ACCESSIBLE_CFG_BIT = 6;
  localparam int APM_SLEEP_TIMER_MODE_BIT = 5;
  localparam logic [7:0] APM_LOW_POWER_CFG_MASK = 8'h60;
  // Field positions in data_output_format_cfg
  localparam int APM_UNFILTERED_BIT = 7;
  localparam int APM_SHADOW_DIS_BIT = 6;
  localparam logic [7:0] APM_DATA_OUTPUT_FORMAT_CFG_MASK = 8'hc0;
  // Clock and sleep-phase timing
  localparam int APM_CLK_PERIOD_NS = 100;
  localparam int APM_SLEEP_UNIT_US = 500;
  localparam int APM_SLEEP_UNIT_CYCLES = (APM_SLEEP_UNIT_US * 1000) / APM_CLK_PERIOD_NS;
  // Decoded power states
  typedef enum logic [2:0] {
    APM_PS_NORMAL,
    APM_PS_DEEP_SLEEP,
    APM_PS_LOW_POWER,
    APM_PS_SUSPEND,
    APM_PS_ILLEGAL
  } apm_power_state_t;
  // Sleep phase phases
  typedef enum logic [1:0] {
    APM_LP_IDLE,
    APM_LP_AWAKE,
    APM_LP_SLEEP
  } apm_lp_phase_t;
endpackage : apm_pkg

// ### logic/apm_sleep_timer.sv
// Sleep-phase timer: counts sleep duration in 0.5 ms units and pulses on expiry
`timescale 1ns/100ps
module apm_sleep_timer
  import apm_pkg::*;
#(
  parameter int UNIT_CYCLES = APM_SLEEP_UNIT_CYCLES
) (
  input wire logic clock_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic start_i, // Start a new sleep phase
  input wire logic [3:0] code_i, // Sleep duration code
  output logic busy_o, // Sleep phase running
  output logic done_o // One-cycle pulse at end of phase
);
  if (UNIT_CYCLES < 1) begin : g_bad_unit
    $error("apm_sleep_timer: UNIT_CYCLES must be at least 1");
  end

  // Units of 0.5 ms for each duration code
  function automatic logic [10:0] units_of(input logic [3:0] code);
    unique case (code)
      4'h6: units_of = 11'h002;
      4'h7: units_of = 11'h004;
      4'h8: units_of = 11'h008;
      4'h9: units_of = 11'h00c;
      4'ha: units_of = 11'h014;
      4'hb: units_of = 11'h032;
      4'hc: units_of = 11'h064;
      4'hd: units_of = 11'h0c8;
      4'he: units_of = 11'h3e8;
      4'hf: units_of = 11'h7d0;
      default: units_of = 11'h001;
    endcase
  endfunction : units_of

  logic [31:0] tick_reg;
  logic [10:0] units_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_reg <= 32'h0;
      units_reg <= 11'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin // [RULE3]
        busy_o <= 1'b1;
        tick_reg <= 32'(UNIT_CYCLES - 1);
        units_reg <= units_of(code_i);
      end else if (busy_o) begin
        if (tick_reg != 32'h0) begin
          tick_reg <= tick_reg - 32'h1;
        end else if (units_reg == 11'h1) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          units_reg <= units_reg - 11'h1;
          tick_reg <= 32'(UNIT_CYCLES - 1);
        end
      end
    end
  end

  chk_timer_done_ends: assert property (@(posedge clock_i) disable iff (!resetn_i)
    done_o |-> !busy_o && $past(busy_o)) // [RULE3]
    else $error("sleep timer done without a running phase");
endmodule : apm_sleep_timer

// ### logic/apm_cfg_top.sv
// Power state, low-power and output format configuration with acceleration shadow lock
// Function
// [RULE1] Decode suspend, low-power, deep-sleep bits into four states; other combinations illegal.
// [RULE2] Only permitted power state transitions are requested and supported.
// [RULE3] Low-power sleep phase lasts 0.5 ms to 1 s per sleep-duration code.
// [RULE4] Host rewrites non-default settings after leaving deep sleep.
// [RULE5] Config select bit: 0 lean, 1 accessible; applies to suspend and low-power.
// [RULE6] Lean config blocks FIFO access in suspend and low-power; host slows writes.
// [RULE7] Accessible config keeps FIFO readable and full-speed writes in low-power.
// [RULE8] Sleep timer mode bit: 0 event-driven, 1 equidistant time-base.
// [RULE9] Even FIFO sampling in low-power only with equidistant time-base.
// [RULE10] Shadow-disable 1 turns lock off; resets to 1 in 8-bit mode.
// [RULE11] Reading an axis low byte freezes its high byte.
// [RULE12] Reading the high byte releases the freeze.
// [RULE13] Unfiltered output select: 1 unfiltered, 0 filtered, filtered after reset.
// [RULE14] Host writes zero to reserved bits.
`timescale 1ns/100ps
module apm_cfg_top
  import apm_pkg::*;
#(
  parameter int UNIT_CYCLES = APM_SLEEP_UNIT_CYCLES,
  parameter int AXES = 3
) (
  input wire logic clock_i, // System clock, 10 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic mode8_i, // Eight-bit output mode strap
  input wire logic [7:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after read strobe
  input wire logic [AXES-1:0] lsb_rd_i, // Low data byte of axis read
  input wire logic [AXES-1:0] msb_rd_i, // High data byte of axis read
  input wire logic sample_i, // New filtered and unfiltered sample ready
  input wire logic [AXES*8-1:0] filt_msb_i, // Filtered high bytes
  input wire logic [AXES*8-1:0] unfilt_msb_i, // Unfiltered high bytes
  output logic [AXES*8-1:0] msb_o, // High data bytes as seen by host
  output logic [2:0] power_state_o, // Decoded power state
  output logic state_illegal_o, // Illegal power bit combination
  output logic sleeping_o, // In sleep phase of low-power cycle
  output logic wake_o, // One-cycle pulse: low-power wake phase begins
  output logic fifo_access_o, // FIFO readable
  output logic slow_writes_o, // Register writes must be slowed
  output logic equidistant_o, // Equidistant FIFO sampling guaranteed
  output logic shadow_en_o // Coherency lock active
);
  if (AXES < 1 || AXES > 8) begin : g_bad_axes
    $error("apm_cfg_top: AXES must be 1 to 8");
  end

  logic mode8_meta_reg;
  logic mode8_sync_reg;
  logic strap_done_reg;
  logic [1:0] strap_age_reg;
  logic [7:0] pwr_reg;
  logic [7:0] lpc_reg;
  logic [7:0] fmt_reg;
  logic [AXES-1:0] lock_reg;
  apm_power_state_t ps_next;
  apm_power_state_t ps_reg;
  apm_lp_phase_t phase_reg;
  logic timer_start;
  logic timer_busy;
  logic timer_done;

  function automatic apm_power_state_t decode_ps(input logic [7:0] v);
    unique case ({v[APM_SUSPEND_BIT], v[APM_LOWPOWER_EN_BIT], v[APM_DEEP_SLEEP_BIT]})
      3'h0: decode_ps = APM_PS_NORMAL;
      3'h1: decode_ps = APM_PS_DEEP_SLEEP;
      3'h2: decode_ps = APM_PS_LOW_POWER;
      3'h4: decode_ps = APM_PS_SUSPEND;
      default: decode_ps = APM_PS_ILLEGAL;
    endcase
  endfunction : decode_ps

  // Permitted transitions: deep sleep leaves only to normal; suspend and low power go via normal or each other
  function automatic logic allowed(input apm_power_state_t from, input apm_power_state_t to);
    if (to == APM_PS_ILLEGAL) begin
      allowed = 1'b0;
    end else if (from == to || from == APM_PS_NORMAL || from == APM_PS_ILLEGAL) begin
      allowed = 1'b1;
    end else begin
      allowed = (from == APM_PS_DEEP_SLEEP) ? (to == APM_PS_NORMAL) : (to != APM_PS_DEEP_SLEEP);
    end
  endfunction : allowed

  // Strap passes two flip-flops; reset takes constants only
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode8_meta_reg <= 1'b0;
      mode8_sync_reg <= 1'b0;
    end else begin
      mode8_meta_reg <= mode8_i;
      mode8_sync_reg <= mode8_meta_reg;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_reg <= APM_POWER_STATE_CTRL_RESET;
      lpc_reg <= APM_LOW_POWER_CFG_RESET;
    end else if (wr_i) begin
      // Reserved bits are stored as zero whatever the host writes
      if (addr_i == APM_POWER_STATE_CTRL_OFFS) begin
        pwr_reg <= wdata_i & APM_POWER_STATE_CTRL_MASK; // [RULE14]
      end
      if (addr_i == APM_LOW_POWER_CFG_OFFS) begin
        lpc_reg <= wdata_i & APM_LOW_POWER_CFG_MASK;
      end
    end
  end

  // Shadow-disable default follows the strap, caught once at the third edge after release,
  // the first edge at which the synchronised strap holds the pin's value
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fmt_reg <= APM_DATA_OUTPUT_FORMAT_CFG_RESET;
      strap_age_reg <= 2'h0;
      strap_done_reg <= 1'b0;
    end else begin
      strap_age_reg <= {strap_age_reg[0], 1'b1};
      strap_done_reg <= strap_age_reg[1];
      if (wr_i && addr_i == APM_DATA_OUTPUT_FORMAT_CFG_OFFS) begin
        fmt_reg <= wdata_i & APM_DATA_OUTPUT_FORMAT_CFG_MASK;
      end else if (strap_age_reg[1] && !strap_done_reg && mode8_sync_reg) begin
        fmt_reg[APM_SHADOW_DIS_BIT] <= 1'b1; // [RULE10]
      end
    end
  end

  // Read mux
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        APM_POWER_STATE_CTRL_OFFS: rdata_o <= pwr_reg;
        APM_LOW_POWER_CFG_OFFS: rdata_o <= lpc_reg;
        APM_DATA_OUTPUT_FORMAT_CFG_OFFS: rdata_o <= fmt_reg;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // A forbidden request keeps the previous state; the written bits remain visible
  always_comb begin
    ps_next = ps_reg;
    if (allowed(ps_reg, decode_ps(pwr_reg))) begin // [RULE2]
      ps_next = decode_ps(pwr_reg); // [RULE1]
    end else if (decode_ps(pwr_reg) == APM_PS_ILLEGAL) begin
      ps_next = APM_PS_ILLEGAL; // [RULE1]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ps_reg <= APM_PS_NORMAL;
      power_state_o <= 3'(APM_PS_NORMAL);
      state_illegal_o <= 1'b0;
    end else begin
      ps_reg <= ps_next;
      power_state_o <= 3'(ps_next);
      state_illegal_o <= (ps_next == APM_PS_ILLEGAL);
    end
  end

  // Low-power cycle: wake phase one cycle, then sleep for the coded duration
  assign timer_start = (ps_reg == APM_PS_LOW_POWER) && (phase_reg == APM_LP_AWAKE);

  apm_sleep_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .start_i(timer_start),
    .code_i(pwr_reg[APM_SLEEP_DUR_LSB +: 4]),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg <= APM_LP_IDLE;
      sleeping_o <= 1'b0;
      wake_o <= 1'b0;
    end else if (ps_reg != APM_PS_LOW_POWER) begin
      phase_reg <= APM_LP_IDLE;
      sleeping_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      unique case (phase_reg)
        APM_LP_IDLE: begin
          phase_reg <= APM_LP_AWAKE;
          wake_o <= 1'b1;
        end
        APM_LP_AWAKE: begin
          phase_reg <= APM_LP_SLEEP; // [RULE3]
          sleeping_o <= 1'b1;
        end
        APM_LP_SLEEP: begin
          if (timer_done) begin
            phase_reg <= APM_LP_AWAKE;
            sleeping_o <= 1'b0;
            wake_o <= 1'b1;
          end
        end
      endcase
    end
  end

  // Access policy in low-power states
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_access_o <= 1'b1;
      slow_writes_o <= 1'b0;
      equidistant_o <= 1'b0;
    end else begin
      if (ps_next == APM_PS_SUSPEND || ps_next == APM_PS_LOW_POWER) begin
        fifo_access_o <= lpc_reg[APM_ACCESSIBLE_CFG_BIT]; // [RULE5] [RULE6] [RULE7]
        slow_writes_o <= !lpc_reg[APM_ACCESSIBLE_CFG_BIT]; // [RULE6]
      end else begin
        fifo_access_o <= (ps_next == APM_PS_NORMAL);
        slow_writes_o <= 1'b0;
      end
      // Event-driven time-base gives no spacing guarantee
      equidistant_o <= (ps_next == APM_PS_LOW_POWER) && lpc_reg[APM_SLEEP_TIMER_MODE_BIT]; // [RULE8] [RULE9]
    end
  end

  // Shadow lock per axis; a high-byte read releases, a low-byte read freezes
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shadow_en_o <= 1'b1;
    end else begin
      shadow_en_o <= !fmt_reg[APM_SHADOW_DIS_BIT]; // [RULE10]
    end
  end

  generate
    for (genvar ax = 0; ax < AXES; ax++) begin : g_axis
      always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
          lock_reg[ax] <= 1'b0;
          msb_o[ax*8 +: 8] <= 8'h00;
        end else begin
          if (msb_rd_i[ax] || fmt_reg[APM_SHADOW_DIS_BIT]) begin
            lock_reg[ax] <= 1'b0; // [RULE12]
          end else if (lsb_rd_i[ax]) begin
            lock_reg[ax] <= 1'b1; // [RULE11]
          end
          if (sample_i && !lock_reg[ax]) begin
            msb_o[ax*8 +: 8] <= fmt_reg[APM_UNFILTERED_BIT] ? unfilt_msb_i[ax*8 +: 8]
                                                             : filt_msb_i[ax*8 +: 8]; // [RULE13]
          end
        end
      end

      chk_lock_holds_msb: assert property (@(posedge clock_i) disable iff (!resetn_i)
        lock_reg[ax] |=> $stable(msb_o[ax*8 +: 8])) // [RULE11]
        else $error("high byte changed while frozen");
      chk_msb_read_frees: assert property (@(posedge clock_i) disable iff (!resetn_i)
        msb_rd_i[ax] |=> !lock_reg[ax]) // [RULE12]
        else $error("high byte read did not release the freeze");
    end
  endgenerate

  chk_illegal_flag: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (decode_ps(pwr_reg) == APM_PS_ILLEGAL) |=> state_illegal_o) // [RULE1]
    else $error("illegal power bits not flagged");
  chk_deep_exit_normal: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (ps_reg == APM_PS_DEEP_SLEEP && decode_ps(pwr_reg) != APM_PS_ILLEGAL)
    |=> (ps_reg == APM_PS_DEEP_SLEEP || ps_reg == APM_PS_NORMAL)) // [RULE2]
    else $error("forbidden exit from deep sleep");
  chk_lean_blocks_fifo: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (power_state_o == 3'(APM_PS_SUSPEND) && !lpc_reg[APM_ACCESSIBLE_CFG_BIT] && $stable(lpc_reg)
     && $stable(power_state_o)) |-> !fifo_access_o && slow_writes_o) // [RULE6]
    else $error("lean config left FIFO open");
  chk_accessible_fifo: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (power_state_o == 3'(APM_PS_LOW_POWER) && lpc_reg[APM_ACCESSIBLE_CFG_BIT] && $stable(lpc_reg)
     && $stable(power_state_o)) |-> fifo_access_o && !slow_writes_o) // [RULE7]
    else $error("accessible config blocked FIFO");
  chk_equidistant_mode: assert property (@(posedge clock_i) disable iff (!resetn_i)
    equidistant_o |-> $past(lpc_reg[APM_SLEEP_TIMER_MODE_BIT])) // [RULE8] [RULE9]
    else $error("equidistant flag without time-base bit");
  chk_sleep_then_wake: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (timer_done && phase_reg == APM_LP_SLEEP && ps_reg == APM_PS_LOW_POWER) |=> wake_o && !sleeping_o) // [RULE3]
    else $error("no wake after sleep phase");
  chk_sleep_timer_busy: assert property (@(posedge clock_i) disable iff (!resetn_i)
    sleeping_o |-> timer_busy || timer_done) // [RULE3]
    else $error("sleep phase shown without a running timer");
  chk_shadow_follows: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $past(fmt_reg[APM_SHADOW_DIS_BIT]) |-> !shadow_en_o) // [RULE10]
    else $error("lock enabled while disabled");
endmodule : apm_cfg_top

// ### testbench/apm_cfg_top_tb.sv
// Self-checking testbench for the power state, low-power and output format configuration block
`timescale 1ns/100ps
module apm_cfg_top_tb;
  import apm_pkg::*;
  // Short sleep unit keeps the longest sleep phase to a few thousand cycles
  localparam int UC = 4;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mode8_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] lsb_rd_i = 3'h0;
  logic [2:0] msb_rd_i = 3'h0;
  logic sample_i = 1'b0;
  logic [23:0] filt_msb_i = 24'h000000;
  logic [23:0] unfilt_msb_i = 24'h000000;
  logic [7:0] rdata_o;
  logic [23:0] msb_o;
  logic [2:0] power_state_o;
  logic state_illegal_o, sleeping_o, wake_o, fifo_access_o, slow_writes_o, equidistant_o, shadow_en_o;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int len0, len;
  logic [7:0] ps_data [8] = '{8'h40, 8'h80, 8'h00, 8'h20, 8'h40, 8'h00, 8'hc0, 8'h00};
  logic [2:0] ps_exp [8] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h1, 3'h0, 3'h4, 3'h0};
  int units [16] = '{1, 1, 1, 1, 1, 1, 2, 4, 8, 12, 20, 50, 100, 200, 1000, 2000};

  apm_cfg_top #(.UNIT_CYCLES(UC), .AXES(3)) i_apm_cfg_top (
    .clock_i(clock_i), .resetn_i(resetn_i), .mode8_i(mode8_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lsb_rd_i(lsb_rd_i), .msb_rd_i(msb_rd_i),
    .sample_i(sample_i), .filt_msb_i(filt_msb_i), .unfilt_msb_i(unfilt_msb_i), .msb_o(msb_o),
    .power_state_o(power_state_o), .state_illegal_o(state_illegal_o), .sleeping_o(sleeping_o),
    .wake_o(wake_o), .fifo_access_o(fifo_access_o), .slow_writes_o(slow_writes_o),
    .equidistant_o(equidistant_o), .shadow_en_o(shadow_en_o)
  );

  initial begin
    forever #50 clock_i = ~clock_i;
  end

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Longest run is the sleep sweep, about 14000 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("[FAIL] %0t: run did not finish", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd_chk

  task automatic set_ps(input logic [7:0] d, input logic [2:0] exp);
    wr_reg(APM_POWER_STATE_CTRL_OFFS, d);
    repeat (2) @(posedge clock_i);
    #1;
    chk(power_state_o, exp);
    chk(state_illegal_o, exp == 3'h4);
  endtask : set_ps

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_cyc

  task automatic samp(input logic [23:0] f, input logic [23:0] u);
    @(posedge clock_i);
    filt_msb_i <= f;
    unfilt_msb_i <= u;
    sample_i <= 1'b1;
    @(posedge clock_i);
    sample_i <= 1'b0;
    wait_cyc(2);
  endtask : samp

  task automatic byte_rd(input logic [2:0] lo, input logic [2:0] hi);
    @(posedge clock_i);
    lsb_rd_i <= lo;
    msb_rd_i <= hi;
    @(posedge clock_i);
    lsb_rd_i <= 3'h0;
    msb_rd_i <= 3'h0;
  endtask : byte_rd

  task automatic do_reset(input logic m8);
    @(posedge clock_i);
    mode8_i <= m8;
    resetn_i <= 1'b0;
    wait_cyc(8);
    chk({power_state_o, fifo_access_o, shadow_en_o, sleeping_o}, {3'h0, 3'b110});
    @(posedge clock_i);
    resetn_i <= 1'b1;
    wait_cyc(4);
  endtask : do_reset

  // Sleep phase length in cycles for one duration code
  task automatic sleep_len(input logic [3:0] code, output int n);
    int w;
    set_ps({3'b010, code, 1'b0}, 3'h2);
    chk(wake_o, 1'b1);
    w = 0;
    while (sleeping_o !== 1'b1 && w < 50) begin
      wait_cyc(1);
      w++;
    end
    n = 0;
    while (sleeping_o === 1'b1 && n < 10000) begin
      wait_cyc(1);
      n++;
    end
    chk(wake_o, 1'b1);
    set_ps(8'h00, 3'h0);
  endtask : sleep_len

  initial begin
    do_reset(1'b0);
    rd_chk(APM_POWER_STATE_CTRL_OFFS, 8'h00);
    rd_chk(APM_LOW_POWER_CFG_OFFS, 8'h00);
    rd_chk(APM_DATA_OUTPUT_FORMAT_CFG_OFFS, 8'h00);
    chk(shadow_en_o, 1'b1);
    // Reserved bits read back as zero; unmapped place ignored
    wr_reg(APM_POWER_STATE_CTRL_OFFS, 8'hff);
    wr_reg(APM_LOW_POWER_CFG_OFFS, 8'hff);
    wr_reg(8'h20, 8'hff);
    rd_chk(APM_POWER_STATE_CTRL_OFFS, 8'hfe);
    rd_chk(APM_LOW_POWER_CFG_OFFS, 8'h60);
    rd_chk(8'h20, 8'h00);
    chk(state_illegal_o, 1'b1);
    wr_reg(APM_LOW_POWER_CFG_OFFS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      set_ps(ps_data[i], ps_exp[i]);
    end
    // Settings are restored after deep sleep, reserved bits written as zero
    wr_reg(APM_DATA_OUTPUT_FORMAT_CFG_OFFS, 8'h00);
    // Lean configuration in low power, then timer mode and accessible configuration
    set_ps(8'h40, 3'h2);
    chk({fifo_access_o, slow_writes_o, equidistant_o}, 3'b010);
    wr_reg(APM_LOW_POWER_CFG_OFFS, 8'h20);
    wait_cyc(3);
    chk(equidistant_o, 1'b1);
    wr_reg(APM_LOW_POWER_CFG_OFFS, 8'h40);
    wait_cyc(3);
    chk({fifo_access_o, slow_writes_o, equidistant_o}, 3'b100);
    set_ps(8'h00, 3'h0);
    wr_reg(APM_LOW_POWER_CFG_OFFS, 8'h00);
    set_ps(8'h80, 3'h3);
    chk({fifo_access_o, slow_writes_o}, 2'b01);
    set_ps(8'h00, 3'h0);
    chk({fifo_access_o, slow_writes_o}, 2'b10);
    // Sleep phase lengths against the shortest code
    sleep_len(4'h0, len0);
    for (int c = 1; c < 16; c++) begin
      sleep_len(c[3:0], len);
      chk(len - len0, (units[c] - 1) * UC);
    end
    // Filtered source after reset, then lock and release per axis
    samp(24'h332211, 24'hccbbaa);
    chk(msb_o, 24'h332211);
    byte_rd(3'b001, 3'b000);
    samp(24'h665544, 24'hccbbaa);
    chk(msb_o, 24'h665511);
    byte_rd(3'b000, 3'b001);
    samp(24'h998877, 24'hccbbaa);
    chk(msb_o, 24'h998877);
    byte_rd(3'b010, 3'b010);
    samp(24'h121212, 24'hccbbaa);
    chk(msb_o, 24'h121212);
    wr_reg(APM_DATA_OUTPUT_FORMAT_CFG_OFFS, 8'h80);
    samp(24'h343434, 24'hccbbaa);
    chk(msb_o, 24'hccbbaa);
    wr_reg(APM_DATA_OUTPUT_FORMAT_CFG_OFFS, 8'h7f);
    rd_chk(APM_DATA_OUTPUT_FORMAT_CFG_OFFS, 8'h40);
    wait_cyc(2);
    chk(shadow_en_o, 1'b0);
    byte_rd(3'b111, 3'b000);
    samp(24'h565656, 24'hccbbaa);
    chk(msb_o, 24'h565656);
    // Eight-bit mode strap: lock comes up disabled
    do_reset(1'b1);
    rd_chk(APM_DATA_OUTPUT_FORMAT_CFG_OFFS, 8'h40);
    chk(shadow_en_o, 1'b0);
    end_sim();
  end
endmodule : apm_cfg_top_tb
